/* File: hw/flash_seq_cfg.svh */
// opcode, geometry, field and timing constants of the flash command sequencer
`ifndef FLASH_SEQ_CFG_SVH
`define FLASH_SEQ_CFG_SVH
`define OP_SET_WEL       8'h06
`define OP_QUAD_PROG     8'h32
`define OP_SECT_3B       8'h20
`define OP_SECT_4B       8'h21
`define OP_HALF_3B       8'h52
`define OP_HALF_4B       8'h5C
`define OP_FULL_3B       8'hD8
`define OP_FULL_4B       8'hDC
`define OP_CHIP_A        8'h60
`define OP_CHIP_B        8'hC7
`define OP_WIDE_ON       8'hB7
`define OP_WIDE_OFF      8'hE9
`define OP_MAKER_PART    8'h90
`define OP_IDENT         8'h9F
`define OP_UNIQUE        8'h4B
`define BIT_CNT_W        20
`define OPC_BITS         20'h00008
`define ADDR_BITS_NARROW 20'h00018
`define ADDR_BITS_WIDE   20'h00020
`define DUMMY_BITS       20'h00008
`define MAKER_PART_BITS  20'h00010
`define IDENT_BITS       20'h00018
`define UNIQUE_BITS      20'h00080
`define PAGE_MASK        32'h000000FF
`define PAGE_LAST        9'h0FF
`define SECT_MASK        32'h00000FFF
`define HALF_MASK        32'h00007FFF
`define FULL_MASK        32'h0000FFFF
`define PROT_GRANULE     32'h00010000
`define CLK_PERIOD_NS    4
`endif

/* File: hw/flash_seq_pkg.sv */
// types shared by the flash command sequencer
package flash_seq_pkg;
`include "flash_seq_cfg.svh"
   typedef enum logic [1:0] {WIPE_SECTOR, WIPE_HALF, WIPE_FULL, WIPE_CHIP} wipe_kind_t;
   typedef enum logic [1:0] {CORE_IDLE, CORE_STREAM, CORE_WAIT} core_phase_t;
   typedef struct packed {
      logic [`BIT_CNT_W-1:0] bits;
      logic [7:0]            opcode;
      logic [31:0]           addr;
      logic [7:0]            shreg;
      logic                  quad;
      logic                  seq;
      logic [7:0]            page_idx;
      logic [255:0]          mask;
      logic [1:0]            wip_s;
      logic [1:0]            ads_s;
      logic [1:0]            qe_s;
   } link_regs_t;
   typedef struct packed {
      logic [2:0]  cs_s;
      logic        seen;
      logic        write_latch_flag;
      logic        op_in_progress_flag;
      logic        wide_address_flag;
      core_phase_t phase;
      logic [8:0]  idx;
      logic [31:0] cnt;
      logic [31:0] page;
      logic        we;
      logic [31:0] waddr;
      logic [7:0]  wdata;
      logic        erase;
      logic [31:0] eaddr;
      wipe_kind_t  ekind;
   } core_regs_t;
endpackage

/* File: hw/flash_seq.sv */
// serial flash program, erase, address mode and identification sequencer
//
// Overview of operation
// [R1] quad program 32H takes address and data on four lines, only with quad enable
// [R2] host must set the write latch before any program or erase
// [R3] over 256 data bytes: only the last 256 are programmed, same page
// [R4] under 256 bytes: only addressed bytes change, rest of page untouched
// [R5] program runs only if select rises on a byte boundary after data
// [R6] select rise starts timed cycle; busy flag 1 then 0; latch cleared early
// [R7] program or erase into a protected region is not executed
// [R8] chip erase ignored when any region is protected
// [R9] sector erase 20H or 21H; any address inside selects the sector
// [R10] half block erase 52H or 5CH; any address inside the block
// [R11] full block erase D8H or DCH; any address inside the block
// [R12] sector and block erases need select rise right after last address bit
// [R13] chip erase 60H or C7H, no address, select rise right after opcode
// [R14] host holds select low from opcode through last byte
// [R15] addresses are 24 bits unless 4-byte opcode or wide mode; 90H keeps 24 address bits in wide mode
// [R16] B7H sets the wide address flag
// [R17] E9H clears the wide address flag
// [R18] wide mode changes only the address length, decode stays the same
// [R19] 90H with zero address returns maker then part code, MSB first
// [R20] 9FH returns maker, type, capacity; select rise ends it any time
// [R21] identification read not decoded while a cycle runs; cycle unaffected
// [R22] 4BH, zero address, dummy byte, then 128-bit unique identifier
// [R23] program data past the page end wraps to the page start
// [R24] program or erase ignored while the write latch is clear
`timescale 1ns/1ns
module flash_seq
   import flash_seq_pkg::*;
#(
   parameter int             MEM_AW    = 25,
   parameter int             T_PP_NS   = 2000,
   parameter int             T_SE_NS   = 4000,
   parameter int             T_BE1_NS  = 8000,
   parameter int             T_BE2_NS  = 12000,
   parameter int             T_CE_NS   = 16000,
   parameter logic [7:0]     MAKER_ID  = 8'h5A,            // arbitrary value
   parameter logic [7:0]     PART_ID   = 8'h3C,            // arbitrary value
   parameter logic [7:0]     MEM_TYPE  = 8'h41,            // arbitrary value
   parameter logic [7:0]     CAPACITY  = 8'h19,            // arbitrary value
   parameter logic [127:0]   UNIQUE_ID = 128'h0123456789ABCDEFFEDCBA9876543210 // arbitrary
)(
   input  wire logic         clk_i,
   input  wire logic         rstn_i,
   input  wire logic         sclk_i,
   input  wire logic         cs_n_i,
   input  wire logic [3:0]   io_i,
   output logic [3:0]        io_o,
   output logic [3:0]        io_oe_o,
   input  wire logic         quad_io_enable_bit_i,
   input  wire logic [4:0]   protect_range_bits_i,
   output logic              write_latch_flag_o,
   output logic              op_in_progress_flag_o,
   output logic              wide_address_flag_o,
   output logic              prog_we_o,
   output logic [31:0]       prog_addr_o,
   output logic [7:0]        prog_data_o,
   output logic              erase_o,
   output logic [31:0]       erase_addr_o,
   output wipe_kind_t        erase_kind_o
);
   localparam logic [31:0] MEM_SIZE = 32'(64'h1 << MEM_AW);
   localparam int P = `CLK_PERIOD_NS;
   localparam logic [31:0] PP_CYC  = 32'((T_PP_NS + P - 1) / P);
   localparam logic [31:0] SE_CYC  = 32'((T_SE_NS + P - 1) / P);
   localparam logic [31:0] BE1_CYC = 32'((T_BE1_NS + P - 1) / P);
   localparam logic [31:0] BE2_CYC = 32'((T_BE2_NS + P - 1) / P);
   localparam logic [31:0] CE_CYC  = 32'((T_CE_NS + P - 1) / P);

   link_regs_t ln_q, ln_d;
   core_regs_t cr_q, cr_d;
   logic       fresh_q;
   logic [7:0] page_buf [256];
   logic       buf_we;
   logic [7:0] buf_data;
   logic       rd_on;
   logic       rd_bit;
   logic [3:0] io_q, oe_q;

   // opcodes that carry a 32-bit address whatever the mode
   function automatic logic is_4b(input logic [7:0] op);
      is_4b = (op == `OP_SECT_4B) || (op == `OP_HALF_4B) || (op == `OP_FULL_4B);
   endfunction

   // does the region [a & ~m, a | m] touch the protected range
   function automatic logic prot_hit(input logic [31:0] a, input logic [31:0] m,
                                     input logic [4:0] bp);
      logic [31:0] span;
      span = `PROT_GRANULE << (bp[3:0] - 4'h1);
      if (bp[3:0] == 4'h0)
         prot_hit = 1'b0;
      else if (span >= MEM_SIZE)
         prot_hit = 1'b1;
      else if (bp[4])
         prot_hit = (a & ~m) < span;
      else
         prot_hit = (a | m) >= (MEM_SIZE - span);
   endfunction

   // ---------------- link domain (serial clock) ----------------

   // first edge of a frame; select high presets it, so no edge is needed after a frame
   always_ff @(posedge sclk_i or posedge cs_n_i or negedge rstn_i)
   begin
      if (!rstn_i)
         fresh_q <= 1'b1;
      else if (cs_n_i)
         fresh_q <= 1'b1;
      else
         fresh_q <= 1'b0;
   end

   // shift in opcode, address and data; everything stays frozen once the clock stops
   always_comb
   begin
      logic [`BIT_CNT_W-1:0] cur;
      logic [`BIT_CNT_W-1:0] nxt;
      logic [`BIT_CNT_W-1:0] aend;
      logic                  quad_now;
      cur      = fresh_q ? '0 : ln_q.bits;
      quad_now = ln_q.quad && !fresh_q;
      nxt      = cur + (quad_now ? `BIT_CNT_W'(4) : `BIT_CNT_W'(1));
      aend     = `OPC_BITS + (((ln_q.ads_s[1] || is_4b(ln_q.opcode))              // R15 R18
                 && ln_q.opcode != `OP_MAKER_PART) ? `ADDR_BITS_WIDE : `ADDR_BITS_NARROW);
      ln_d       = ln_q;
      buf_we     = 1'b0;
      buf_data   = ln_q.shreg;
      ln_d.wip_s = {ln_q.wip_s[0], cr_q.op_in_progress_flag};
      ln_d.ads_s = {ln_q.ads_s[0], cr_q.wide_address_flag};
      ln_d.qe_s  = {ln_q.qe_s[0], quad_io_enable_bit_i};
      ln_d.bits  = nxt;
      if (fresh_q)
      begin
         ln_d.quad = 1'b0;
         ln_d.addr = '0;
         ln_d.seq  = ~ln_q.seq;   // tells the core a new frame was clocked
      end
      if (cur < `OPC_BITS)
      begin
         ln_d.opcode = {ln_q.opcode[6:0], io_i[0]};
         if (nxt == `OPC_BITS)
            ln_d.quad = (ln_d.opcode == `OP_QUAD_PROG) && ln_q.qe_s[1];           // R1
      end
      else if (cur < aend)
      begin
         ln_d.addr = quad_now ? {ln_q.addr[27:0], io_i} : {ln_q.addr[30:0], io_i[0]};
         if (nxt == aend)
         begin
            ln_d.page_idx = ln_d.addr[7:0];
            // a read during a running program must not wipe the slots being drained
            if (!ln_q.wip_s[1])
               ln_d.mask = '0;                                                     // R4
         end
      end
      else if (quad_now)
      begin
         ln_d.shreg = {ln_q.shreg[3:0], io_i};                                     // R1
         // buffer is left alone while a cycle drains it
         if (nxt[2:0] == 3'h0 && !ln_q.wip_s[1])
         begin
            buf_we                  = 1'b1;                                        // R3
            buf_data                = ln_d.shreg;
            ln_d.mask[ln_q.page_idx] = 1'b1;                                       // R4
            ln_d.page_idx           = ln_q.page_idx + 8'h01;                       // R23
         end
      end
   end

   always_ff @(posedge sclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         ln_q <= '0;
      else
         ln_q <= ln_d;
   end

   // page buffer; later bytes at the same slot overwrite earlier ones
   always_ff @(posedge sclk_i)
   begin
      if (buf_we)
         page_buf[ln_q.page_idx] <= buf_data;
   end

   // identification output bit for the coming falling edge
   always_comb
   begin
      logic [`BIT_CNT_W-1:0] idx;
      logic [`BIT_CNT_W-1:0] ustart;
      logic [23:0]           ident;
      logic [15:0]           mkpt;
      idx    = '0;
      ustart = `OPC_BITS + `DUMMY_BITS + (ln_q.ads_s[1] ? `ADDR_BITS_WIDE : `ADDR_BITS_NARROW);
      ident  = {MAKER_ID, MEM_TYPE, CAPACITY};
      mkpt   = {MAKER_ID, PART_ID};
      rd_on  = 1'b0;
      rd_bit = 1'b0;
      if (!fresh_q)
      begin
         case (ln_q.opcode)
            `OP_IDENT:
            begin
               idx = ln_q.bits - `OPC_BITS;
               if (!ln_q.wip_s[1] && ln_q.bits >= `OPC_BITS && idx < `IDENT_BITS)  // R21
               begin
                  rd_on  = 1'b1;                                                   // R20
                  rd_bit = ident[5'h17 - idx[4:0]];
               end
            end
            `OP_MAKER_PART:
            begin
               idx = ln_q.bits - (`OPC_BITS + `ADDR_BITS_NARROW);
               if (ln_q.bits >= `OPC_BITS + `ADDR_BITS_NARROW)
               begin
                  rd_on  = 1'b1;                                                   // R19
                  rd_bit = mkpt[4'hF - idx[3:0]];
               end
            end
            `OP_UNIQUE:
            begin
               idx = ln_q.bits - ustart;
               if (ln_q.bits >= ustart && idx < `UNIQUE_BITS)
               begin
                  rd_on  = 1'b1;                                                   // R22
                  rd_bit = UNIQUE_ID[7'h7F - idx[6:0]];
               end
            end
            default:
            begin
               rd_on  = 1'b0;
               rd_bit = 1'b0;
            end
         endcase
      end
   end

   // data out on falling edges; select high releases the line at once
   always_ff @(negedge sclk_i or posedge cs_n_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         io_q <= 4'h0;
         oe_q <= 4'h0;
      end
      else if (cs_n_i)
      begin
         io_q <= 4'h0;
         oe_q <= 4'h0;
      end
      else
      begin
         io_q <= {2'h0, rd_bit, 1'h0};
         oe_q <= {2'h0, rd_on, 1'h0};
      end
   end

   // ---------------- core domain ----------------
   // link fields are read only after the synced select rise, when the serial
   // clock stands still; the host must keep select high for 4 core cycles

   logic        cs_rise;
   logic        new_frame;
   logic        go_ok;
   logic        go_prog;
   logic        go_erase;
   logic        go_wide_on;
   logic        go_wide_off;
   logic [`BIT_CNT_W-1:0] aend_c;
   logic [31:0] emask;
   logic [31:0] ecyc;
   wipe_kind_t  ekind;
   logic        ek_ok;

   // command decode at the end of a frame
   always_comb
   begin
      cs_rise   = cr_q.cs_s[1] && !cr_q.cs_s[2];
      new_frame = ln_q.seq != cr_q.seen;
      go_ok     = cs_rise && new_frame && !cr_q.op_in_progress_flag;
      aend_c    = `OPC_BITS + ((cr_q.wide_address_flag || is_4b(ln_q.opcode))                    // R15
                  ? `ADDR_BITS_WIDE : `ADDR_BITS_NARROW);
      ek_ok     = 1'b1;
      emask     = `SECT_MASK;
      ecyc      = SE_CYC;
      ekind     = WIPE_SECTOR;
      case (ln_q.opcode)
         `OP_SECT_3B, `OP_SECT_4B:                                                 // R9
         begin
            ekind = WIPE_SECTOR;
            emask = `SECT_MASK;
            ecyc  = SE_CYC;
         end
         `OP_HALF_3B, `OP_HALF_4B:                                                 // R10
         begin
            ekind = WIPE_HALF;
            emask = `HALF_MASK;
            ecyc  = BE1_CYC;
         end
         `OP_FULL_3B, `OP_FULL_4B:                                                 // R11
         begin
            ekind = WIPE_FULL;
            emask = `FULL_MASK;
            ecyc  = BE2_CYC;
         end
         `OP_CHIP_A, `OP_CHIP_B:                                                   // R13
         begin
            ekind = WIPE_CHIP;
            emask = MEM_SIZE - 32'h1;
            ecyc  = CE_CYC;
         end
         default:
            ek_ok = 1'b0;
      endcase
      go_prog = go_ok && cr_q.write_latch_flag && ln_q.opcode == `OP_QUAD_PROG                  // R24
                && quad_io_enable_bit_i && ln_q.quad                               // R1
                && ln_q.bits > aend_c && ln_q.bits[2:0] == 3'h0                     // R5
                && !prot_hit(ln_q.addr, `PAGE_MASK, protect_range_bits_i);         // R7
      go_erase = go_ok && cr_q.write_latch_flag && ek_ok                                        // R24
                 && ((ekind == WIPE_CHIP)
                     ? (ln_q.bits == `OPC_BITS && protect_range_bits_i[3:0] == 4'h0) // R8 R13
                     : (ln_q.bits == aend_c                                         // R12
                        && !prot_hit(ln_q.addr, emask, protect_range_bits_i)));    // R7
      go_wide_on  = go_ok && ln_q.opcode == `OP_WIDE_ON && ln_q.bits == `OPC_BITS;
      go_wide_off = go_ok && ln_q.opcode == `OP_WIDE_OFF && ln_q.bits == `OPC_BITS;
   end

   // status flags and the self-timed cycle
   always_comb
   begin
      cr_d       = cr_q;
      cr_d.cs_s  = {cr_q.cs_s[1:0], cs_n_i};
      cr_d.we    = 1'b0;
      cr_d.erase = 1'b0;
      if (cs_rise)
         cr_d.seen = ln_q.seq;
      if (go_ok && ln_q.opcode == `OP_SET_WEL && ln_q.bits == `OPC_BITS)
         cr_d.write_latch_flag = 1'b1;
      if (go_wide_on)
         cr_d.wide_address_flag = 1'b1;                                                          // R16
      if (go_wide_off)
         cr_d.wide_address_flag = 1'b0;                                                          // R17
      case (cr_q.phase)
         CORE_IDLE:
         begin
            if (go_prog)
            begin
               cr_d.phase = CORE_STREAM;                                           // R6
               cr_d.op_in_progress_flag   = 1'b1;
               cr_d.write_latch_flag   = 1'b0;
               cr_d.idx   = 9'h000;
               cr_d.page  = ln_q.addr & ~`PAGE_MASK;                               // R23
            end
            else if (go_erase)
            begin
               cr_d.phase = CORE_WAIT;                                             // R6
               cr_d.op_in_progress_flag   = 1'b1;
               cr_d.write_latch_flag   = 1'b0;
               cr_d.erase = 1'b1;
               cr_d.eaddr = ln_q.addr & ~emask;
               cr_d.ekind = ekind;
               cr_d.cnt   = ecyc;
            end
         end
         CORE_STREAM:
         begin
            // only slots that received data are written
            cr_d.we    = ln_q.mask[cr_q.idx[7:0]];                                 // R4
            cr_d.waddr = cr_q.page | {24'h0, cr_q.idx[7:0]};
            cr_d.wdata = page_buf[cr_q.idx[7:0]];                                  // R3
            cr_d.idx   = cr_q.idx + 9'h001;
            if (cr_q.idx == `PAGE_LAST)
            begin
               cr_d.phase = CORE_WAIT;
               cr_d.cnt   = PP_CYC;
            end
         end
         CORE_WAIT:
         begin
            if (cr_q.cnt <= 32'h1)
            begin
               cr_d.phase = CORE_IDLE;
               cr_d.op_in_progress_flag   = 1'b0;                                                  // R6
            end
            else
               cr_d.cnt = cr_q.cnt - 32'h1;
         end
         default:
            cr_d.phase = CORE_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         cr_q <= '{cs_s: 3'h7, ekind: WIPE_SECTOR, phase: CORE_IDLE, default: '0};
      else
         cr_q <= cr_d;
   end

   assign io_o                  = io_q;
   assign io_oe_o               = oe_q;
   assign write_latch_flag_o    = cr_q.write_latch_flag;
   assign op_in_progress_flag_o = cr_q.op_in_progress_flag;
   assign wide_address_flag_o   = cr_q.wide_address_flag;
   assign prog_we_o             = cr_q.we;
   assign prog_addr_o           = cr_q.waddr;
   assign prog_data_o           = cr_q.wdata;
   assign erase_o               = cr_q.erase;
   assign erase_addr_o          = cr_q.eaddr;
   assign erase_kind_o          = cr_q.ekind;

   // ---------------- checks ----------------
   a_cycle_start_flags: assert property (@(posedge clk_i) disable iff (!rstn_i) // R6
      (go_prog || go_erase) |=> op_in_progress_flag_o && !write_latch_flag_o)
      else $error("busy or latch flag wrong after cycle start");
   a_latch_required: assert property (@(posedge clk_i) disable iff (!rstn_i) // R24
      (go_prog || go_erase) |-> write_latch_flag_o)
      else $error("cycle started with write latch clear");
   a_quad_gate: assert property (@(posedge clk_i) disable iff (!rstn_i) // R1
      go_prog |-> quad_io_enable_bit_i && ln_q.opcode == `OP_QUAD_PROG)
      else $error("quad program accepted without quad enable");
   a_prog_byte_edge: assert property (@(posedge clk_i) disable iff (!rstn_i) // R5
      go_prog |-> ln_q.bits[2:0] == 3'h0 && ln_q.bits >= aend_c + `BIT_CNT_W'(8))
      else $error("program accepted off a byte boundary");
   a_wipe_framing: assert property (@(posedge clk_i) disable iff (!rstn_i) // R12
      (go_erase && ekind != WIPE_CHIP) |-> ln_q.bits == aend_c)
      else $error("erase accepted with wrong frame length");
   a_chip_guard: assert property (@(posedge clk_i) disable iff (!rstn_i) // R8
      (erase_o && erase_kind_o == WIPE_CHIP) |-> $past(protect_range_bits_i[3:0]) == 4'h0)
      else $error("chip erase issued with protection set");
   a_wide_enter: assert property (@(posedge clk_i) disable iff (!rstn_i) // R16
      go_wide_on |=> wide_address_flag_o [*2])
      else $error("wide address flag not set");
   a_wide_exit: assert property (@(posedge clk_i) disable iff (!rstn_i) // R17
      go_wide_off |=> !wide_address_flag_o)
      else $error("wide address flag not cleared");
   a_page_stays: assert property (@(posedge clk_i) disable iff (!rstn_i) // R23
      prog_we_o |-> prog_addr_o[31:8] == cr_q.page[31:8] && cr_q.phase != CORE_IDLE)
      else $error("program write left its page");
   a_stream_to_wait: assert property (@(posedge clk_i) disable iff (!rstn_i) // R6
      (cr_q.phase == CORE_STREAM && cr_q.idx == `PAGE_LAST) |=> cr_q.phase == CORE_WAIT
      ##1 op_in_progress_flag_o)
      else $error("program stream did not hand over to the timer");
   a_ident_quiet: assert property (@(posedge sclk_i) disable iff (!rstn_i) // R21
      (!fresh_q && ln_q.opcode == `OP_IDENT && ln_q.wip_s[1]) |-> !rd_on)
      else $error("identification decoded during a busy cycle");
   a_buf_quad_only: assert property (@(posedge sclk_i) disable iff (!rstn_i) // R3
      buf_we |-> ln_q.quad && ln_q.opcode == `OP_QUAD_PROG && !ln_q.wip_s[1])
      else $error("page buffer written outside a quad program");

endmodule // flash_seq

/* File: testbench/spi_host_model.sv */
// host spi controller model driving select, clock and data lines
`timescale 1ns/1ns
module spi_host_model (
   output logic       sclk_o,
   output logic       cs_n_o,
   output logic [3:0] io_o,
   input  wire logic  miso_i
);
   // the clock stands still low between frames
   initial
   begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      io_o   = 4'hA;
   end
   task automatic sel();
      cs_n_o = 1'b0;
      #62;
   endtask
   // high time covers the four core cycles needed between frames
   task automatic desel();
      #62 cs_n_o = 1'b1;
      #40;
   endtask
   // data changes after the fall, sampled by both sides on the rise
   task automatic shift(input logic [31:0] v, input int n, input bit quad,
                        output logic [31:0] r);
      r = '0;
      for (int i = n - 1; i >= 0; i--)
      begin
         io_o = quad ? v[i*4+:4] : {~io_o[3:1], v[i]};
         #62 sclk_o = 1'b1;
         r = {r[30:0], miso_i};
         #63 sclk_o = 1'b0;
      end
      io_o = ~io_o; // released lines never keep a stale value
   endtask
endmodule // spi_host_model

/* File: testbench/test_serial_flash_program_erase_id.sv */
// self-checking bench of the flash command sequencer
`timescale 1ns/1ns
module test_serial_flash_program_erase_id;
   import flash_seq_pkg::*;
   localparam logic [127:0] UID = 128'hC3A5F00F_12345678_9ABCDEF0_0F1E2D3C;
   logic clk_i = 1'b0, rstn_i = 1'b0, quad = 1'b0, write_latch_flag, op_in_progress_flag, wide, pwe, ers, sclk, cs_n, miso;
   logic [4:0]  bp = 5'h00;
   logic [3:0]  hio, dio, doe;
   logic [31:0] pa, ea, r;
   logic [7:0]  pd;
   wipe_kind_t  ek;
   int          fail_count = 0, n_compared = 0, ne = 0;
   logic [31:0] pas [$];
   logic [7:0]  pds [$];
   always #2 clk_i = ~clk_i;
   assign miso = doe[1] ? dio[1] : hio[1];
   spi_host_model i_spi_host_model (.sclk_o(sclk), .cs_n_o(cs_n), .io_o(hio), .miso_i(miso));
   flash_seq #(.MAKER_ID(8'hA5), .PART_ID(8'h17), .MEM_TYPE(8'h62), .CAPACITY(8'h2E),
      .UNIQUE_ID(UID))
   i_flash_seq (.clk_i(clk_i), .rstn_i(rstn_i), .sclk_i(sclk), .cs_n_i(cs_n),
      .io_i({hio[3:2], miso, hio[0]}), .io_o(dio), .io_oe_o(doe), .quad_io_enable_bit_i(quad),
      .protect_range_bits_i(bp), .write_latch_flag_o(write_latch_flag), .op_in_progress_flag_o(op_in_progress_flag),
      .wide_address_flag_o(wide), .prog_we_o(pwe), .prog_addr_o(pa), .prog_data_o(pd),
      .erase_o(ers), .erase_addr_o(ea), .erase_kind_o(ek));
   // record every programmed byte and every erase start
   always @(posedge clk_i)
   begin
      if (pwe) pas.push_back(pa);
      if (pwe) pds.push_back(pd);
      if (ers) ne++;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic cmd(input logic [7:0] op, input logic [31:0] a, input int n, input int rd);
      i_spi_host_model.sel();
      i_spi_host_model.shift({24'h0, op}, 8, 1'b0, r);
      if (n > 0) i_spi_host_model.shift(a, n, 1'b0, r);
      if (rd > 0) i_spi_host_model.shift(32'h0, rd, 1'b0, r);
      i_spi_host_model.desel();
   endtask
   // bounded wait for the self-timed cycle to finish
   task automatic idle();
      for (int i = 0; i < 5000 && op_in_progress_flag !== 1'b0; i++) @(posedge clk_i);
      check(op_in_progress_flag, 0, "cycle end");
   endtask
   task automatic t_wide();
      cmd(8'hB7, 0, 0, 0);
      check(wide, 1, "wide on");
      cmd(8'hE9, 0, 0, 0);
      check(wide, 0, "wide off");
   endtask
   task automatic t_erase();
      logic [7:0]  op [6] = '{8'h20, 8'h52, 8'hD8, 8'h21, 8'h5C, 8'hDC};
      logic [31:0] msk [3] = '{32'hFFF, 32'h7FFF, 32'hFFFF};
      logic [31:0] a;
      cmd(8'h20, 32'h12345, 24, 0);
      check(ne, 0, "erase with latch clear");
      for (int k = 0; k < 6; k++)
      begin
         a = (k < 3) ? 32'h00ABCDEF : 32'h01ABCDEF;
         cmd(8'h06, 0, 0, 0);
         cmd(op[k], a, (k < 3) ? 24 : 32, 0);
         check(ne, k + 1, "erase start");
         check(ek, k % 3, "erase kind");
         check(ea, a & ~msk[k % 3], "erase base");
         check({op_in_progress_flag, write_latch_flag}, 2'b10, "busy and latch");
         idle();
      end
      cmd(8'h06, 0, 0, 0);
      cmd(8'h20, 0, 23, 0);
      check(ne, 6, "short address");
   endtask
   task automatic t_chip();
      @(negedge clk_i) bp = 5'h01;
      cmd(8'h60, 0, 0, 0);
      check(ne, 6, "chip erase protected");
      @(negedge clk_i) bp = 5'h00;
      cmd(8'hC7, 0, 0, 0);
      check(ne, 7, "chip erase count");
      check(ek, WIPE_CHIP, "chip erase kind");
      check(ea, 32'h0, "chip erase base");
      idle();
   endtask
   // quad program: address at the page end so the third byte wraps
   task automatic pframe(input logic [31:0] d, input int n);
      i_spi_host_model.sel();
      i_spi_host_model.shift(32'h32, 8, 1'b0, r);
      i_spi_host_model.shift(32'hFE, 6, 1'b1, r);
      i_spi_host_model.shift(d, n, 1'b1, r);
      i_spi_host_model.desel();
      repeat (300) @(posedge clk_i);
   endtask
   task automatic t_prog();
      logic [31:0] ea3 [3] = '{32'h0, 32'hFE, 32'hFF};
      logic [7:0]  ed3 [3] = '{8'h33, 8'h11, 8'h22};
      cmd(8'h06, 0, 0, 0);
      pframe(32'h112233, 6);
      check(pas.size(), 0, "quad disabled");
      @(negedge clk_i) quad = 1'b1;
      pframe(32'h1122334, 7);
      check(pas.size(), 0, "partial byte");
      check(write_latch_flag, 1, "latch kept");
      pframe(32'h112233, 6);
      check(pas.size(), 3, "bytes written");
      for (int k = 0; k < 3; k++)
      begin
         check(pas[k], ea3[k], "byte slot");
         check(pds[k], ed3[k], "byte data");
      end
      idle();
   endtask
   task automatic t_ident();
      cmd(8'h9F, 0, 0, 24);
      check(r, 32'hA5622E, "ident");
      cmd(8'h90, 0, 24, 16);
      check(r, 32'hA517, "maker part");
      cmd(8'h4B, 0, 32, 32);
      check(r, UID[127:96], "unique id");
      // wide mode: 32 address bits before the dummy byte
      cmd(8'hB7, 0, 0, 0);
      i_spi_host_model.sel();
      i_spi_host_model.shift(32'h4B, 8, 1'b0, r);
      i_spi_host_model.shift(32'h0, 32, 1'b0, r);
      i_spi_host_model.shift(32'h0, 8, 1'b0, r);
      i_spi_host_model.shift(32'h0, 32, 1'b0, r);
      i_spi_host_model.desel();
      check(r, UID[127:96], "unique id wide");
   endtask
   task automatic end_of_test();
      $display("compared %0d failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(negedge clk_i);
      rstn_i = 1'b1;
      repeat (4) @(negedge clk_i);
      t_wide();
      t_erase();
      t_chip();
      t_prog();
      t_ident();
      end_of_test();
   end
   // the sequence needs about 150 us; twice that means a hang
   initial
   begin
      #300000;
      fail_count++;
      end_of_test();
   end
endmodule // test_serial_flash_program_erase_id
